// file: hw/rtcirq_top.sv
`timescale 1ns/10ps
module rtcirq_top (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       osc_pin,
  input  wire logic       clock_out_block_pin,
  input  wire logic       halt,
  input  wire logic       sec_evt,
  input  wire logic       min_evt,
  input  wire logic       countdown_evt,
  input  wire logic       alarm_evt,
  input  wire logic [1:0] countdown_src,
  input  wire logic       countdown_n_one,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic            int_out,
  output logic            int_oe,
  output logic            clkout_out,
  output logic            clkout_oe,
  output logic            one_hz_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [6:0] trim_mag(input logic [6:0] v);
    trim_mag = v[6] ? 7'(-v) : v;
  endfunction

  // wider pulses for slow sources; n of one halves the width for the 4096 Hz and 64 Hz sources only
  function automatic logic [rtcirq_pkg::PW_W-1:0] cd_width(input logic [1:0] src, input logic one);
    if (src == rtcirq_pkg::CD_SRC_4K)
      cd_width = one ? rtcirq_pkg::PW_1_8192 : rtcirq_pkg::PW_1_4096;
    else if (src == rtcirq_pkg::CD_SRC_64)
      cd_width = one ? rtcirq_pkg::PW_1_128 : rtcirq_pkg::PW_1_64;
    else
      cd_width = rtcirq_pkg::PW_1_64;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic osc_s1_r, osc_s2_r, osc_d_r;
  logic blk_s1_r, blk_s2_r;
  logic osc_tick;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_d_r  <= 1'b0;
      blk_s1_r <= 1'b1;
      blk_s2_r <= 1'b1;
    end else begin
      osc_s1_r <= osc_pin;
      osc_s2_r <= osc_s1_r;
      osc_d_r  <= osc_s2_r;
      blk_s1_r <= clock_out_block_pin;
      blk_s2_r <= blk_s1_r;
    end
  end

  assign osc_tick = osc_s2_r & ~osc_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] ctrl1_r, ctrl1_nxt;
  logic [7:0] ctrl2_r, ctrl2_nxt;
  logic [7:0] trim_r, trim_nxt;
  logic [2:0] cof_r, cof_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       rvalid_r;
  logic       wr1, wr2;
  logic       tick_set, cd_set, al_set;

  assign wr1 = reg_wr && (reg_addr == rtcirq_pkg::CTRL1_ADDR);
  assign wr2 = reg_wr && (reg_addr == rtcirq_pkg::CTRL2_ADDR);

  // seconds win when both enables are on
  assign tick_set = ctrl2_r[rtcirq_pkg::C2_SEC_EN] ? sec_evt
                  : (ctrl2_r[rtcirq_pkg::C2_MIN_EN] & min_evt);
  assign cd_set   = countdown_evt;
  assign al_set   = alarm_evt;

  always_comb begin
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    trim_nxt  = trim_r;
    cof_nxt   = cof_r;
    if (wr1)
      ctrl1_nxt = reg_wdata;
    // non-flag bits take the written value; callers rewrite them as read
    if (wr2) begin
      ctrl2_nxt = reg_wdata;
      ctrl2_nxt[rtcirq_pkg::C2_TICK_F]  = ctrl2_r[rtcirq_pkg::C2_TICK_F]  & reg_wdata[rtcirq_pkg::C2_TICK_F];
      ctrl2_nxt[rtcirq_pkg::C2_ALARM_F] = ctrl2_r[rtcirq_pkg::C2_ALARM_F] & reg_wdata[rtcirq_pkg::C2_ALARM_F];
      ctrl2_nxt[rtcirq_pkg::C2_CD_F]    = ctrl2_r[rtcirq_pkg::C2_CD_F]    & reg_wdata[rtcirq_pkg::C2_CD_F];
    end
    // sets applied last, only a write can clear a flag
    if (tick_set) ctrl2_nxt[rtcirq_pkg::C2_TICK_F]  = 1'b1;
    if (al_set)   ctrl2_nxt[rtcirq_pkg::C2_ALARM_F] = 1'b1;
    if (cd_set)   ctrl2_nxt[rtcirq_pkg::C2_CD_F]    = 1'b1;
    if (reg_wr && reg_addr == rtcirq_pkg::TRIM_ADDR)
      trim_nxt = reg_wdata;
    if (reg_wr && reg_addr == rtcirq_pkg::CLKOUT_ADDR)
      cof_nxt = reg_wdata[2:0];
    unique case (reg_addr)
      rtcirq_pkg::CTRL1_ADDR:  rdata_nxt = ctrl1_r;
      rtcirq_pkg::CTRL2_ADDR:  rdata_nxt = ctrl2_r;
      rtcirq_pkg::TRIM_ADDR:   rdata_nxt = trim_r;
      rtcirq_pkg::CLKOUT_ADDR: rdata_nxt = {5'h00, cof_r};
      default:                 rdata_nxt = 8'h00;
    endcase
    if (!reg_rd)
      rdata_nxt = rdata_r;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl1_r  <= rtcirq_pkg::CTRL1_RST;
      ctrl2_r  <= rtcirq_pkg::CTRL2_RST;
      trim_r   <= rtcirq_pkg::TRIM_RST;
      cof_r    <= rtcirq_pkg::COF_RST;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      ctrl1_r  <= ctrl1_nxt;
      ctrl2_r  <= ctrl2_nxt;
      trim_r   <= trim_nxt;
      cof_r    <= cof_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and trim sequencer

  logic [8:0] pre_r, pre_nxt;
  logic [5:0] sub_r, sub_nxt;
  logic [6:0] min_idx_r, min_idx_nxt;
  logic [6:0] remain_r, remain_nxt;
  logic [6:0] pend_r, pend_nxt;
  logic       one_hz_r, one_hz_nxt;
  logic       hz64, corr_now, coarse;
  logic [6:0] period, ni, rem, give, step_sum;
  logic [1:0] step;

  assign hz64     = osc_tick && (pre_r == rtcirq_pkg::PRE_64HZ_LAST);
  assign corr_now = hz64 && (pend_r != 7'h00);
  assign coarse   = trim_r[rtcirq_pkg::TRIM_COARSE];
  assign period   = coarse ? rtcirq_pkg::MIN_COARSE : rtcirq_pkg::MIN_NORMAL;

  always_comb begin
    pre_nxt     = osc_tick ? 9'(pre_r + 9'h001) : pre_r;
    // a positive trim skips one 64 Hz step, a negative one holds a step
    step        = corr_now ? (trim_r[rtcirq_pkg::TRIM_SIGN] ? 2'h0 : 2'h2) : 2'h1;
    step_sum    = {1'b0, sub_r} + {5'h00, step};
    sub_nxt     = hz64 ? step_sum[5:0] : sub_r;
    one_hz_nxt  = hz64 && step_sum[6];
    min_idx_nxt = min_idx_r;
    remain_nxt  = remain_r;
    ni          = (min_idx_r == 7'(period - 7'h01)) ? 7'h00 : 7'(min_idx_r + 7'h01);
    rem         = (ni == 7'h00) ? trim_mag(trim_r[6:0]) : remain_r;
    give        = 7'h00;
    if (min_evt) begin
      min_idx_nxt = ni;
      // excess beyond sixty lands in the last minute of the hour
      if (coarse && ni == rtcirq_pkg::LAST_MIN)
        give = rem;
      else
        give = (rem != 7'h00) ? 7'h01 : 7'h00;
      remain_nxt = 7'(rem - give);
    end
    pend_nxt = 7'(pend_r + give - {6'h00, corr_now});
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_r     <= 9'h000;
      sub_r     <= 6'h00;
      min_idx_r <= 7'h00;
      remain_r  <= 7'h00;
      pend_r    <= 7'h00;
      one_hz_r  <= 1'b0;
    end else begin
      pre_r     <= pre_nxt;
      sub_r     <= sub_nxt;
      min_idx_r <= min_idx_nxt;
      remain_r  <= remain_nxt;
      pend_r    <= pend_nxt;
      one_hz_r  <= one_hz_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pulses

  rtcirq_pulse_if tick_pi ();
  rtcirq_pulse_if cd_pi ();
  rtcirq_pulse_if corr_pi ();

  logic psel;
  assign psel = ctrl2_r[rtcirq_pkg::C2_PULSE_SEL];

  assign tick_pi.tick   = osc_tick;
  assign tick_pi.width  = rtcirq_pkg::PW_1_64;
  assign tick_pi.start  = tick_set & psel;
  assign tick_pi.cancel = wr2 & ~reg_wdata[rtcirq_pkg::C2_TICK_F];

  assign cd_pi.tick   = osc_tick;
  assign cd_pi.width  = cd_width(countdown_src, countdown_n_one);
  assign cd_pi.start  = cd_set & psel & ctrl2_r[rtcirq_pkg::C2_CD_EN];
  assign cd_pi.cancel = wr2 & ~reg_wdata[rtcirq_pkg::C2_CD_F];

  assign corr_pi.tick   = osc_tick;
  assign corr_pi.width  = rtcirq_pkg::PW_1_128;
  assign corr_pi.start  = corr_now & ctrl1_r[rtcirq_pkg::C1_CORR_CTL];
  assign corr_pi.cancel = wr1 & reg_wdata[rtcirq_pkg::C1_CORR_CTL];

  rtcirq_pulse u_tick_pulse (.clk(clk), .nrst(nrst), .p(tick_pi));
  rtcirq_pulse u_cd_pulse   (.clk(clk), .nrst(nrst), .p(cd_pi));
  rtcirq_pulse u_corr_pulse (.clk(clk), .nrst(nrst), .p(corr_pi));

  ////////////////////////////////////////////////////////////////////////////
  // interrupt and clock out pins

  logic       int_oe_r, int_oe_nxt;
  logic       ck_oe_r, ck_oe_nxt;
  logic       tick_lvl, cd_lvl, al_lvl, wave, ck_on;

  assign tick_lvl = ~psel & ctrl2_r[rtcirq_pkg::C2_TICK_F]
                  & (ctrl2_r[rtcirq_pkg::C2_MIN_EN] | ctrl2_r[rtcirq_pkg::C2_SEC_EN]);
  assign cd_lvl   = ~psel & ctrl2_r[rtcirq_pkg::C2_CD_F] & ctrl2_r[rtcirq_pkg::C2_CD_EN];
  assign al_lvl   = ctrl2_r[rtcirq_pkg::C2_ALARM_F] & ctrl2_r[rtcirq_pkg::C2_ALARM_EN];

  always_comb begin
    // any one source holds the pin low and hides the others
    int_oe_nxt = tick_lvl | cd_lvl | al_lvl | tick_pi.active
               | (cd_pi.active & ctrl2_r[rtcirq_pkg::C2_CD_EN]) | corr_pi.active;
    unique case (cof_r)
      3'h0:    wave = osc_s2_r;
      3'h1:    wave = pre_r[0];
      3'h2:    wave = pre_r[1];
      3'h3:    wave = pre_r[2];
      3'h4:    wave = pre_r[3];
      3'h5:    wave = pre_r[4];
      3'h6:    wave = sub_r[5];
      3'h7:    wave = 1'b1;
    endcase
    ck_on = (cof_r != rtcirq_pkg::COF_OFF) & blk_s2_r;
    // open drain: only the low half is driven, except halt with codes 3 to 6 drives it low throughout
    ck_oe_nxt = ck_on & (~wave | (halt & (cof_r >= rtcirq_pkg::COF_HALT_MIN)));
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      int_oe_r <= 1'b0;
      ck_oe_r  <= 1'b0;
    end else begin
      int_oe_r <= int_oe_nxt;
      ck_oe_r  <= ck_oe_nxt;
    end
  end

  assign int_out     = 1'b0;
  assign int_oe      = int_oe_r;
  assign clkout_out  = 1'b0;
  assign clkout_oe   = ck_oe_r;
  assign one_hz_tick = one_hz_r;
  assign reg_rdata   = rdata_r;
  assign reg_rvalid  = rvalid_r;
endmodule

// file: include/rtcirq_pkg.sv
package rtcirq_pkg;
  // register addresses
  localparam logic [7:0] CTRL1_ADDR  = 8'h00;
  localparam logic [7:0] CTRL2_ADDR  = 8'h01;
  localparam logic [7:0] TRIM_ADDR   = 8'h0D;
  localparam logic [7:0] CLKOUT_ADDR = 8'h0E;
  // interrupt_control_status field positions
  localparam int C2_MIN_EN    = 7;
  localparam int C2_SEC_EN    = 6;
  localparam int C2_TICK_F    = 5;
  localparam int C2_PULSE_SEL = 4;
  localparam int C2_ALARM_F   = 3;
  localparam int C2_CD_F      = 2;
  localparam int C2_ALARM_EN  = 1;
  localparam int C2_CD_EN     = 0;
  // first control register and trim fields
  localparam int C1_CORR_CTL  = 2;
  localparam int TRIM_COARSE  = 7;
  localparam int TRIM_SIGN    = 6;
  // values after reset
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] TRIM_RST  = 8'h00;
  localparam logic [2:0] COF_RST   = 3'h0;
  // clock out selections
  localparam logic [2:0] COF_HALT_MIN = 3'h3;
  localparam logic [2:0] COF_OFF      = 3'h7;
  // countdown source codes
  localparam logic [1:0] CD_SRC_4K  = 2'h0;
  localparam logic [1:0] CD_SRC_64  = 2'h1;
  // pulse widths in 32.768 kHz oscillator periods
  localparam int PW_W = 10;
  localparam logic [PW_W-1:0] PW_1_64   = 10'h200;
  localparam logic [PW_W-1:0] PW_1_128  = 10'h100;
  localparam logic [PW_W-1:0] PW_1_4096 = 10'h008;
  localparam logic [PW_W-1:0] PW_1_8192 = 10'h004;
  // prescaler and trim sequencing counts
  localparam logic [8:0] PRE_64HZ_LAST = 9'h1FF;
  localparam logic [6:0] MIN_NORMAL    = 7'h78;
  localparam logic [6:0] MIN_COARSE    = 7'h3C;
  localparam logic [6:0] LAST_MIN      = 7'h3B;
endpackage

// file: include/rtcirq_pulse_if.sv
`timescale 1ns/10ps
interface rtcirq_pulse_if;
  logic                       start;
  logic                       cancel;
  logic                       tick;
  logic [rtcirq_pkg::PW_W-1:0] width;
  logic                       active;
  modport ctl (output start, output cancel, output tick, output width, input active);
  modport gen (input start, input cancel, input tick, input width, output active);
endinterface

// file: hw/rtcirq_pulse.sv
`timescale 1ns/10ps
module rtcirq_pulse (
  input wire logic      clk,
  input wire logic      nrst,
  rtcirq_pulse_if.gen   p
);
  logic [rtcirq_pkg::PW_W-1:0] cnt_r;
  logic [rtcirq_pkg::PW_W-1:0] cnt_nxt;
  logic                        act_r;
  logic                        act_nxt;

  // start beats cancel so a fresh event is never swallowed
  always_comb begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    if (p.start) begin
      cnt_nxt = p.width;
      act_nxt = 1'b1;
    end else if (p.cancel) begin
      cnt_nxt = '0;
      act_nxt = 1'b0;
    end else if (p.tick && act_r) begin
      cnt_nxt = cnt_r - 1'b1;
      act_nxt = (cnt_r != 10'h001);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_r <= '0;
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  assign p.active = act_r;
endmodule

// file: verif/rtcirq_host.sv
`timescale 1ns/10ps
module rtcirq_host (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse so a late sample reads garbage
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk) #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk) #1;
    // answer was registered at the edge just passed and stands until the next one
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask
  // read first so control bits go back as they were
  task automatic clr(input logic [7:0] m);
    logic [7:0] v;
    rd(8'h01, v);
    wr(8'h01, (v | 8'h2C) & ~m);
  endtask
endmodule

// file: verif/rtcirq_top_asserts.sv
`timescale 1ns/10ps
module rtcirq_top_asserts (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       clock_out_block_pin,
  input wire logic       sec_evt,
  input wire logic       min_evt,
  input wire logic       countdown_evt,
  input wire logic       alarm_evt,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       int_out,
  input wire logic       int_oe,
  input wire logic       clkout_out,
  input wire logic       clkout_oe
);
  logic corr_r;
  wire  w2 = reg_wr && reg_addr == rtcirq_pkg::CTRL2_ADDR;
  wire  r2 = reg_rd && reg_addr == rtcirq_pkg::CTRL2_ADDR;
  wire  nev = !(sec_evt || min_evt || countdown_evt || alarm_evt);
  wire  qt  = nev && !reg_wr;
  // correction pulses may legally hold the pin, so release checks skip them
  always_ff @(posedge clk) begin
    if (!nrst) corr_r <= 1'b0;
    else if (reg_wr && reg_addr == rtcirq_pkg::CTRL1_ADDR) corr_r <= reg_wdata[2];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  alarm_set_a: assert property (alarm_evt ##1 !w2 ##1 r2 |=> reg_rdata[3])
    else $error("alarm flag not set");
  set_wins_a: assert property (countdown_evt && w2 && !reg_wdata[2] ##1 !w2 ##1 r2 |=> reg_rdata[2])
    else $error("countdown event lost to clear");
  and_clear_a: assert property (w2 && !reg_wdata[3] && !alarm_evt ##1 !alarm_evt && !w2 ##1 r2 |=> !reg_rdata[3])
    else $error("alarm flag not cleared");
  trim_rw_a: assert property (reg_wr && reg_addr == rtcirq_pkg::TRIM_ADDR ##1 !reg_wr
    ##1 reg_rd && reg_addr == rtcirq_pkg::TRIM_ADDR |=> reg_rdata == $past(reg_wdata, 3))
    else $error("trim read back wrong");
  int_od_a: assert property (!int_out)
    else $error("interrupt data not low");
  clk_od_a: assert property (!clkout_out)
    else $error("clock out data not low");
  block_pin_a: assert property (!clock_out_block_pin [*5] |-> !clkout_oe)
    else $error("clock out driven while blocked");
  cof_off_a: assert property (reg_wr && reg_addr == 8'h0E && reg_wdata[2:0] == 3'h7 ##1 !reg_wr [*3] |-> !clkout_oe)
    else $error("clock out driven with code 7");
  alarm_lvl_a: assert property (alarm_evt ##1 !w2 ##1 w2 && reg_wdata[1] && reg_wdata[3] |-> ##[1:3] int_oe)
    else $error("alarm level missing");
  irq_release_a: assert property (!corr_r && nev && w2 && ~|reg_wdata ##1 qt [*3] |-> !int_oe)
    else $error("interrupt held after clear");
endmodule

// file: verif/test_rtc_irq_flags_clkout_trim.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end
module test_rtc_irq_flags_clkout_trim;
  // osc period of 8 clocks instead of 305 keeps 1/64 s pulses short enough to time whole
  localparam int OSC = 8;
  logic       clk;
  logic       nrst;
  logic       osc;
  logic       blk;
  logic       halt;
  logic       n_one;
  logic [1:0] src;
  logic [3:0] ev;
  logic [7:0] v;
  logic [7:0] adr [5] = '{8'h00, 8'h01, 8'h0D, 8'h0E, 8'h05};
  wire        wr;
  wire        rd;
  wire  [7:0] addr;
  wire  [7:0] wd;
  wire  [7:0] rdat;
  wire        rv;
  wire        io;
  wire        ioe;
  wire        co;
  wire        coe;
  int         err_total;
  int         check_count;
  int         n;
  int         hi;
  int         w;
  rtcirq_top uut (.clk(clk), .nrst(nrst), .osc_pin(osc), .clock_out_block_pin(blk), .halt(halt),
    .sec_evt(ev[0]), .min_evt(ev[1]), .countdown_evt(ev[2]), .alarm_evt(ev[3]), .countdown_src(src),
    .countdown_n_one(n_one), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
    .reg_rvalid(rv), .int_out(io), .int_oe(ioe), .clkout_out(co), .clkout_oe(coe), .one_hz_tick());
  rtcirq_host host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdat), .reg_rvalid(rv));
  task automatic step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic fire(input logic [3:0] m);
    step();
    ev = m;
    step();
    ev = 4'h0;
  endtask
  task automatic meas(output int t);
    t = 0;
    for (int i = 0; i < 20 && ioe !== 1'b1; i++) step();
    while (ioe === 1'b1 && t < 6000) begin
      step();
      t++;
    end
  endtask
  // a correction waits for the next 64 Hz step, up to 4096 clocks away
  task automatic await_irq();
    for (int i = 0; i < 4200 && ioe !== 1'b1; i++) step();
  endtask
  task automatic scan(input int k, output int r, output int h);
    logic p;
    p = coe;
    r = 0;
    h = 0;
    repeat (k) begin
      step();
      r += (coe === 1'b1 && p !== 1'b1);
      h += (coe === 1'b1);
      p = coe;
    end
  endtask
  function automatic int cd_w(input int s, input bit one);
    if (s == 0) return one ? 32768 / 8192 : 32768 / 4096;
    if (s == 1) return one ? 32768 / 128 : 32768 / 64;
    return 32768 / 64;
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always #400 osc = ~osc;
  initial begin
    #8000000;
    err_total++;
    print_verdict();
  end
  initial begin
    nrst = 1'b0;
    osc = 1'b0;
    blk = 1'b1;
    halt = 1'b0;
    n_one = 1'b0;
    src = 2'h0;
    ev = 4'h0;
    n = $urandom(59);
    step(3);
    nrst = 1'b1;
    foreach (adr[i]) begin
      host.rd(adr[i], v);
      `CHK("reset value", 8'h00, v)
    end
    scan(64, n, hi);
    `CHK("clkout at reset", 1'b1, n >= 6)
    $display("end reset");
    for (int i = 0; i < 6; i++) begin
      v = (i < 2) ? (i ? 8'h40 : 8'h3F) : 8'($urandom());
      host.wr(8'h0D, v);
      host.rd(8'h0D, adr[0]);
      `CHK("trim", v, adr[0])
    end
    $display("end trim");
    host.wr(8'h01, 8'h40);
    fire(4'hD);
    host.rd(8'h01, v);
    `CHK("flags set", 8'h6C, v)
    host.clr(8'h04);
    host.rd(8'h01, v);
    `CHK("and clear", 8'h68, v)
    fork
      host.wr(8'h01, 8'h68);
      fire(4'h4);
    join
    host.rd(8'h01, v);
    `CHK("set wins", 8'h6C, v)
    `CHK("tick level", 1'b1, ioe)
    host.clr(8'h2C);
    host.rd(8'h01, v);
    `CHK("all cleared", 8'h40, v)
    `CHK("tick released", 1'b0, ioe)
    $display("end flags");
    host.wr(8'h01, 8'h50);
    fire(4'h1);
    meas(w);
    `CHK("tick pulse", 1'b1, w > 32768 / 64 * OSC - 12 && w < 32768 / 64 * OSC + 12)
    fire(4'h1);
    step(100);
    host.clr(8'h20);
    step(3);
    `CHK("tick cut", 1'b0, ioe)
    host.wr(8'h01, 8'h11);
    for (int i = 0; i < 6; i++) begin
      src = 2'(i / 2);
      n_one = i[0];
      fire(4'h4);
      meas(w);
      `CHK("countdown pulse", 1'b1, w > cd_w(i / 2, i[0]) * OSC - 12 && w < cd_w(i / 2, i[0]) * OSC + 12)
    end
    host.wr(8'h01, 8'h01);
    fire(4'h4);
    step(600);
    `CHK("countdown level", 1'b1, ioe)
    host.wr(8'h01, 8'h04);
    step(3);
    `CHK("countdown gated", 1'b0, ioe)
    fire(4'h8);
    host.wr(8'h01, 8'h0F);
    step(600);
    `CHK("alarm level", 1'b1, ioe)
    host.wr(8'h01, 8'h07);
    step(3);
    `CHK("wired or", 1'b1, ioe)
    host.wr(8'h01, 8'h00);
    step(4);
    `CHK("all released", 1'b0, ioe)
    $display("end interrupts");
    host.wr(8'h00, 8'h04);
    host.wr(8'h0D, 8'h82);
    repeat (59) fire(4'h2);
    await_irq();
    `CHK("no early correction", 1'b0, ioe)
    fire(4'h2);
    await_irq();
    meas(w);
    `CHK("correction pulse", 1'b1, w > 32768 / 128 * OSC - 12 && w < 32768 / 128 * OSC + 12)
    fire(4'h2);
    await_irq();
    `CHK("second correction", 1'b1, ioe)
    step(100);
    host.wr(8'h00, 8'h04);
    step(3);
    `CHK("correction cut", 1'b0, ioe)
    $display("end correction");
    for (int c = 0; c < 6; c++) begin
      host.wr(8'h0E, 8'(c));
      step(8);
      scan(1024, n, hi);
      `CHK("clkout rate", 1'b1, n >= (1024 >> c) / OSC - 1 && n <= (1024 >> c) / OSC + 1)
    end
    host.wr(8'h0E, 8'h03);
    halt = 1'b1;
    step(4);
    scan(256, n, hi);
    `CHK("halt low", 256, hi)
    host.wr(8'h0E, 8'h02);
    step(4);
    scan(256, n, hi);
    `CHK("halt no effect", 1'b1, n > 4)
    blk = 1'b0;
    step(6);
    scan(64, n, hi);
    `CHK("block pin", 0, hi)
    blk = 1'b1;
    host.wr(8'h0E, 8'h07);
    step(4);
    $display("end clkout");
    print_verdict();
  end
endmodule
bind rtcirq_top rtcirq_top_asserts chk (.clk(clk), .nrst(nrst), .clock_out_block_pin(clock_out_block_pin),
  .sec_evt(sec_evt), .min_evt(min_evt), .countdown_evt(countdown_evt), .alarm_evt(alarm_evt), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_out(int_out),
  .int_oe(int_oe), .clkout_out(clkout_out), .clkout_oe(clkout_oe));
